// ===== core/sbalu_flag_eval.sv
/*
 * sbalu_flag_eval: sign, zero and parity of a byte or word result,
 * combinational on resFlags, with a registered copy on resFlagsQ.
 * assumes: value is the full 16-bit operand image; only low byte for bytes.
 */
`timescale 1ns/1ps
module sbalu_flag_eval (
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	input  wire logic [15:0]               value,
	input  wire logic                      word,
	output sbalu_pkg::sbalu_res_flags_s    resFlags,
	output sbalu_pkg::sbalu_res_flags_s    resFlagsQ
);

	// parity flag set when the low byte holds an even number of ones
	wire logic evenLow = ~(^value[7:0]);
	wire logic signBit = word ? value[15] : value[7];
	wire logic zeroAll = word ? (value == 16'h0000) : (value[7:0] == 8'h00);

	assign resFlags.sign   = signBit;
	assign resFlags.zero   = zeroAll;
	assign resFlags.parity = evenLow;

	// registered copy for observation of the last evaluated result
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			resFlagsQ <= '0;
		end else begin
			resFlagsQ <= resFlags;
		end
	end

endmodule : sbalu_flag_eval

// ===== core/sbalu_pkg.sv
/*
 * sbalu_pkg: register map, field positions, reset values, flag layout and
 * operation codes for the shift and borrow-subtract datapath slice.
 * assumes: included by every sbalu design file, used by scoped name only.
 */
package sbalu_pkg;

	// wishbone byte offsets, one aligned 32-bit word each
	localparam logic [7:0] ADR_CTRL     = 8'h00;
	localparam logic [7:0] ADR_DEST     = 8'h04;
	localparam logic [7:0] ADR_SRC      = 8'h08;
	localparam logic [7:0] ADR_COUNTIMM = 8'h0c;
	localparam logic [7:0] ADR_COUNTREG = 8'h10;
	localparam logic [7:0] ADR_FLAGS    = 8'h14;
	localparam logic [7:0] ADR_STATUS   = 8'h18;

	// control register fields
	localparam int CTRL_OP_LSB    = 0;
	localparam int CTRL_WORD_BIT  = 2;
	localparam int CTRL_CSEL_BIT  = 3;
	localparam int CTRL_START_BIT = 8;

	// status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;

	// flag word bit positions
	localparam int FLAG_CARRY  = 0;
	localparam int FLAG_PARITY = 2;
	localparam int FLAG_AUX    = 4;
	localparam int FLAG_ZERO   = 6;
	localparam int FLAG_SIGN   = 7;
	localparam int FLAG_TRAP   = 8;
	localparam int FLAG_INTEN  = 9;
	localparam int FLAG_DIR    = 10;
	localparam int FLAG_OVER   = 11;

	// reset values
	localparam logic [15:0] RST_DEST  = 16'h0000;
	localparam logic [15:0] RST_SRC   = 16'h0000;
	localparam logic [15:0] RST_FLAGS = 16'h0000;
	localparam logic [7:0]  RST_COUNT = 8'h00;

	// documented operand width and default count width
	localparam int DATA_W  = 16;
	localparam int COUNT_W = 8;

	typedef enum logic [1:0] {
		SBALU_OP_LOGICAL_LEFT_SHIFT    = 2'h0,
		SBALU_OP_ARITHMETIC_LEFT_SHIFT = 2'h1,
		SBALU_OP_ARITHMETIC_RIGHT_SHIFT = 2'h2,
		SBALU_OP_SUBTRACT_WITH_BORROW  = 2'h3
	} sbalu_op_e;

	typedef struct packed {
		sbalu_op_e op;
		logic      word;
		logic      countFromReg;
	} sbalu_ctrl_s;

	typedef struct packed {
		logic sign;
		logic zero;
		logic parity;
	} sbalu_res_flags_s;

endpackage : sbalu_pkg

// ===== core/sbalu_top.sv
/*
 * sbalu_top: shift-left, arithmetic shift-right and subtract-with-borrow
 * datapath slice with its operand, count and flag registers on wishbone.
 * assumes: classic wishbone master on ref_clk, one request at a time;
 * the core reads results back from destOut and flagsOut.
 */
// Register access over Wishbone and the register offsets are this design's own decisions.
// Contract
// RULE1: left shifts move the operand left one bit per cycle, count times
// RULE2: each left step puts the old top bit in carry and doubles the operand
// RULE3: left shift by one sets overflow when top bit differs from carry
// RULE4: left shifts fill the vacated low bit with zero every step
// RULE5: count comes from immediate or count byte register; any destination
// RULE6: each arithmetic right step puts the low bit in carry, halves operand
// RULE7: arithmetic right shift refills the top bit with the original sign
// RULE8: arithmetic right shift rounds toward minus infinity, not toward zero
// RULE9: right shift by one sets overflow if top two bits differ, else clear
// RULE10: shifts leave auxiliary carry alone, update carry overflow parity sign zero
// RULE11: direction, interrupt enable and trap flags are never changed
// RULE12: borrow subtract writes destination minus source minus carry back
// RULE13: borrow subtract works on bytes and words, signedness does not matter
// RULE14: any operand pairing is served since operands arrive as plain values
// RULE15: a zero shift count leaves destination and every flag untouched
// RULE16: borrow subtract sets carry on borrow and other flags from result
`timescale 1ns/1ps
module sbalu_top #(
	parameter int COUNT_W = sbalu_pkg::COUNT_W
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        wbCyc,
	input  wire logic        wbStb,
	input  wire logic        wbWe,
	input  wire logic [7:0]  wbAdr,
	input  wire logic [3:0]  wbSel,
	input  wire logic [31:0] wbDatW,
	output logic      [31:0] wbDatR,
	output logic             wbAck,
	output logic      [15:0] destOut,
	output logic      [15:0] flagsOut,
	output logic             busyOut,
	output logic             opDone
);

	// elaboration-time refusal of count widths the step counter cannot serve
	if (COUNT_W < 1 || COUNT_W > 8) begin : g_count_w_check
		$error("sbalu_top: COUNT_W must lie in 1..8");
	end

	typedef enum logic [1:0] {
		SBALU_IDLE,
		SBALU_SHIFT
	} sbalu_state_e;

	sbalu_state_e                 state;
	sbalu_state_e                 next_state;
	sbalu_pkg::sbalu_ctrl_s       ctrl;
	logic [15:0]                  dest;
	logic [15:0]                  src;
	logic [15:0]                  flags;
	logic [7:0]                   countImm;
	logic [7:0]                   countReg;
	logic [COUNT_W-1:0]           iterLeft;
	logic [COUNT_W-1:0]           origCount;
	logic                         done;
	logic [15:0]                  next_dest;
	logic [15:0]                  next_flags;
	logic [COUNT_W-1:0]           next_iterLeft;
	logic                         next_done;
	logic                         engineWrite;

	// bus decode
	wire logic        busReq   = wbCyc & wbStb & ~wbAck;
	wire logic        busWr    = busReq & wbWe;
	wire logic        selCtrl  = (wbAdr == sbalu_pkg::ADR_CTRL);
	wire logic        selDest  = (wbAdr == sbalu_pkg::ADR_DEST);
	wire logic        selSrc   = (wbAdr == sbalu_pkg::ADR_SRC);
	wire logic        selCImm  = (wbAdr == sbalu_pkg::ADR_COUNTIMM);
	wire logic        selCReg  = (wbAdr == sbalu_pkg::ADR_COUNTREG);
	wire logic        selFlags = (wbAdr == sbalu_pkg::ADR_FLAGS);
	wire logic        selStat  = (wbAdr == sbalu_pkg::ADR_STATUS);
	wire logic        busy     = (state == SBALU_SHIFT);

	// byte-lane merge for the 16-bit registers
	wire logic [15:0] laneMask = {{8{wbSel[1]}}, {8{wbSel[0]}}};
	wire logic [15:0] destWr   = (dest & ~laneMask) | (wbDatW[15:0] & laneMask);
	wire logic [15:0] srcWr    = (src & ~laneMask) | (wbDatW[15:0] & laneMask);
	wire logic [15:0] flagsWr  = (flags & ~laneMask) | (wbDatW[15:0] & laneMask);

	// control write and start request; ignored while the engine runs
	wire logic        ctrlWr   = busWr & selCtrl & wbSel[0] & ~busy;
	wire logic        startReq = busWr & selCtrl & wbSel[1] & ~busy
		& wbDatW[sbalu_pkg::CTRL_START_BIT];
	wire sbalu_pkg::sbalu_ctrl_s ctrlWrVal = '{
		op:           sbalu_pkg::sbalu_op_e'(wbDatW[sbalu_pkg::CTRL_OP_LSB +: 2]),
		word:         wbDatW[sbalu_pkg::CTRL_WORD_BIT],
		countFromReg: wbDatW[sbalu_pkg::CTRL_CSEL_BIT]
	};
	// start uses the control value written in the same access when present
	wire sbalu_pkg::sbalu_ctrl_s runCtrl = ctrlWr ? ctrlWrVal : ctrl;

	// count source: immediate or count byte register
	wire logic [7:0]  countSel = runCtrl.countFromReg ? countReg : countImm; // see RULE5
	wire logic [COUNT_W-1:0] countNow = countSel[COUNT_W-1:0];

	wire logic isSub   = (runCtrl.op == sbalu_pkg::SBALU_OP_SUBTRACT_WITH_BORROW);
	wire logic isRight = (ctrl.op == sbalu_pkg::SBALU_OP_ARITHMETIC_RIGHT_SHIFT);

	// one shift step on the current destination
	wire logic        topBit   = ctrl.word ? dest[15] : dest[7];
	wire logic [15:0] leftVal  = ctrl.word ? {dest[14:0], 1'b0}
		: {dest[15:8], dest[6:0], 1'b0}; // see RULE2 RULE4
	wire logic [15:0] rightVal = ctrl.word ? {dest[15], dest[15:1]}
		: {dest[15:8], dest[7], dest[7:1]}; // see RULE7 RULE8
	wire logic [15:0] stepVal  = isRight ? rightVal : leftVal;
	wire logic        stepCarry = isRight ? dest[0] : topBit; // see RULE2 RULE6
	wire logic        resTop   = ctrl.word ? stepVal[15] : stepVal[7];
	wire logic        resNext  = ctrl.word ? stepVal[14] : stepVal[6];
	wire logic        singleStep = (origCount == COUNT_W'(1));
	wire logic        leftOver  = resTop ^ stepCarry; // see RULE3
	wire logic        rightOver = singleStep & (resTop ^ resNext); // see RULE9

	// subtract with borrow, byte or word, same bits for signed and unsigned
	wire logic        cin      = flags[sbalu_pkg::FLAG_CARRY];
	wire logic        subWord  = runCtrl.word;
	wire logic [16:0] diffW    = {1'b0, dest} - {1'b0, src} - {16'h0000, cin}; // see RULE12
	wire logic [8:0]  diffB    = {1'b0, dest[7:0]} - {1'b0, src[7:0]} - {8'h00, cin};
	wire logic [4:0]  diffNib  = {1'b0, dest[3:0]} - {1'b0, src[3:0]} - {4'h0, cin};
	wire logic [15:0] subVal   = subWord ? diffW[15:0]
		: {dest[15:8], diffB[7:0]}; // see RULE13
	wire logic        subBorrow = subWord ? diffW[16] : diffB[8]; // see RULE16
	wire logic        dTop     = subWord ? dest[15] : dest[7];
	wire logic        sTop     = subWord ? src[15] : src[7];
	wire logic        rTop     = subWord ? subVal[15] : subVal[7];
	wire logic        subOver  = (dTop ^ sTop) & (rTop ^ dTop); // see RULE16

	// shared sign, zero and parity evaluation
	wire logic [15:0] evalVal  = busy ? stepVal : subVal;
	wire logic        evalWord = busy ? ctrl.word : subWord;
	sbalu_pkg::sbalu_res_flags_s resFlags;

	sbalu_flag_eval u_flag_eval (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.value     (evalVal),
		.word      (evalWord),
		.resFlags  (resFlags),
		.resFlagsQ ()
	);

	// engine next state
	always_comb begin
		next_state    = state;
		next_dest     = dest;
		next_flags    = flags;
		next_iterLeft = iterLeft;
		next_done     = done;
		engineWrite   = 1'b0;
		case (state)
			SBALU_IDLE: begin
				if (startReq) begin
					next_done = 1'b0;
					if (isSub) begin
						// single-cycle borrow subtract; direction, ie, trap kept
						engineWrite                      = 1'b1;
						next_dest                        = subVal; // see RULE12 RULE14
						next_flags[sbalu_pkg::FLAG_CARRY]  = subBorrow; // see RULE16
						next_flags[sbalu_pkg::FLAG_OVER]   = subOver;
						next_flags[sbalu_pkg::FLAG_AUX]    = diffNib[4];
						next_flags[sbalu_pkg::FLAG_SIGN]   = resFlags.sign;
						next_flags[sbalu_pkg::FLAG_ZERO]   = resFlags.zero;
						next_flags[sbalu_pkg::FLAG_PARITY] = resFlags.parity; // see RULE11
						next_done                        = 1'b1;
					end else if (countNow == '0) begin
						next_done = 1'b1; // see RULE15
					end else begin
						next_iterLeft = countNow; // see RULE1
						next_state    = SBALU_SHIFT;
					end
				end
			end
			SBALU_SHIFT: begin
				// one bit per cycle; auxiliary carry and control flags kept
				engineWrite                      = 1'b1;
				next_dest                        = stepVal; // see RULE1 RULE6
				next_flags[sbalu_pkg::FLAG_CARRY]  = stepCarry;
				next_flags[sbalu_pkg::FLAG_OVER]   = isRight ? rightOver : leftOver;
				next_flags[sbalu_pkg::FLAG_SIGN]   = resFlags.sign; // see RULE10
				next_flags[sbalu_pkg::FLAG_ZERO]   = resFlags.zero;
				next_flags[sbalu_pkg::FLAG_PARITY] = resFlags.parity; // see RULE11
				next_iterLeft                    = iterLeft - COUNT_W'(1);
				if (iterLeft == COUNT_W'(1)) begin
					next_state = SBALU_IDLE;
					next_done  = 1'b1;
				end
			end
			default: begin
				next_state = SBALU_IDLE;
			end
		endcase
	end

	// engine and operand registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= SBALU_IDLE;
			iterLeft  <= '0;
			origCount <= '0;
			done      <= 1'b0;
			opDone    <= 1'b0;
		end else begin
			state     <= next_state;
			iterLeft  <= next_iterLeft;
			done      <= next_done;
			opDone    <= (state == SBALU_IDLE) ? (startReq & (isSub | countNow == '0))
				: (iterLeft == COUNT_W'(1));
			if (startReq) begin
				origCount <= countNow;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl     <= '{op: sbalu_pkg::SBALU_OP_LOGICAL_LEFT_SHIFT, word: 1'b0,
				countFromReg: 1'b0};
			dest     <= sbalu_pkg::RST_DEST;
			src      <= sbalu_pkg::RST_SRC;
			flags    <= sbalu_pkg::RST_FLAGS;
			countImm <= sbalu_pkg::RST_COUNT;
			countReg <= sbalu_pkg::RST_COUNT;
		end else begin
			if (ctrlWr) begin
				ctrl <= ctrlWrVal;
			end
			if (engineWrite) begin
				dest  <= next_dest;
				flags <= next_flags;
			end else if (busWr & ~busy) begin
				if (selDest) begin
					dest <= destWr;
				end
				if (selFlags) begin
					flags <= flagsWr;
				end
			end
			if (busWr & selSrc & ~busy) begin
				src <= srcWr;
			end
			if (busWr & selCImm & wbSel[0] & ~busy) begin
				countImm <= wbDatW[7:0];
			end
			if (busWr & selCReg & wbSel[0] & ~busy) begin
				countReg <= wbDatW[7:0];
			end
		end
	end

	// read data select; unmapped addresses read zero
	wire logic [31:0] rdCtrl  = {16'h0000, 7'h00, 1'b0, 4'h0, ctrl.countFromReg,
		ctrl.word, ctrl.op};
	wire logic [31:0] rdStat  = {30'h00000000, done, busy};
	wire logic [31:0] rdData  =
		selCtrl  ? rdCtrl :
		selDest  ? {16'h0000, dest} :
		selSrc   ? {16'h0000, src} :
		selCImm  ? {24'h000000, countImm} :
		selCReg  ? {24'h000000, countReg} :
		selFlags ? {16'h0000, flags} :
		selStat  ? rdStat : 32'h00000000;

	// wishbone answer one cycle after the request, dropped the cycle after
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wbAck  <= 1'b0;
			wbDatR <= 32'h00000000;
		end else begin
			wbAck <= busReq;
			if (busReq & ~wbWe) begin
				wbDatR <= rdData;
			end
		end
	end

	// core-facing copies of the architectural results
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			destOut  <= sbalu_pkg::RST_DEST;
			flagsOut <= sbalu_pkg::RST_FLAGS;
			busyOut  <= 1'b0;
		end else begin
			destOut  <= next_dest;
			flagsOut <= next_flags;
			busyOut  <= (next_state == SBALU_SHIFT);
		end
	end

endmodule : sbalu_top

// ===== sim/sbalu_top_chk.sv
/* sbalu_chk: port-level assertions for sbalu_top.
 * assumes: bound to sbalu_top; one wishbone master, one request at a time. */
`timescale 1ns/1ps
module sbalu_chk #(
	parameter int COUNT_W = 8
) (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        wbCyc,
	input wire logic        wbStb,
	input wire logic        wbWe,
	input wire logic [7:0]  wbAdr,
	input wire logic [3:0]  wbSel,
	input wire logic [31:0] wbDatW,
	input wire logic [31:0] wbDatR,
	input wire logic        wbAck,
	input wire logic [15:0] destOut,
	input wire logic [15:0] flagsOut,
	input wire logic        busyOut,
	input wire logic        opDone
);
	logic [1:0] opSeen;
	logic       cselSeen;
	logic       wordSeen;
	logic [7:0] cntImm;
	logic [7:0] cntReg;
	logic [8:0] busyCnt;
	wire        wrTake = wbCyc && wbStb && wbWe && !wbAck && !busyOut && wbSel[0];
	wire [7:0]  cntSel = cselSeen ? cntReg : cntImm;
	wire        isLeft = !opSeen[1];
	wire        isAsr  = (opSeen == 2'h2);
	// shadow of the operation set up by the master
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			opSeen <= 2'h0;
			cselSeen <= 1'b0;
			wordSeen <= 1'b0;
			cntImm <= 8'h00;
			cntReg <= 8'h00;
			busyCnt <= 9'h000;
		end else begin
			if (wrTake && wbAdr == sbalu_pkg::ADR_CTRL) opSeen <= wbDatW[1:0];
			if (wrTake && wbAdr == sbalu_pkg::ADR_CTRL) cselSeen <= wbDatW[3];
			if (wrTake && wbAdr == sbalu_pkg::ADR_CTRL) wordSeen <= wbDatW[2];
			if (wrTake && wbAdr == sbalu_pkg::ADR_COUNTIMM) cntImm <= wbDatW[7:0];
			if (wrTake && wbAdr == sbalu_pkg::ADR_COUNTREG) cntReg <= wbDatW[7:0];
			busyCnt <= busyOut ? busyCnt + 9'h001 : 9'h000;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_ack_next; wbCyc && wbStb && !wbAck |=> wbAck; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing");
	property p_ack_pulse; wbAck |=> !wbAck; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
	property p_done_after_busy; $fell(busyOut) |-> ##[0:1] opDone; endproperty
	a_done_after_busy: assert property (p_done_after_busy) else $error("no done");
	property p_busy_len; $fell(busyOut) |-> busyCnt == {1'b0, cntSel}; endproperty
	a_busy_len: assert property (p_busy_len) else $error("step count off");
	property p_keep_ctl; busyOut |=> $stable(flagsOut[10:8]); endproperty
	a_keep_ctl: assert property (p_keep_ctl) else $error("control flags moved");
	property p_asr_sign;
		busyOut && isAsr |=> $stable(wordSeen ? destOut[15] : destOut[7]);
	endproperty
	a_asr_sign: assert property (p_asr_sign) else $error("sign lost");
	property p_lsh_fill; busyOut && $past(busyOut) && isLeft |=> !destOut[0]; endproperty
	a_lsh_fill: assert property (p_lsh_fill) else $error("low bit not zero");
	property p_asr_ovf; opDone && isAsr && cntSel > 8'h01 |=> !flagsOut[11]; endproperty
	a_asr_ovf: assert property (p_asr_ovf) else $error("overflow not cleared");
	c_asr: cover property (opDone && isAsr);
	c_sub: cover property (opDone && opSeen == 2'h3);
	c_long: cover property ($fell(busyOut) && busyCnt > 9'h00f);
endmodule : sbalu_chk

bind sbalu_top sbalu_chk #(.COUNT_W(COUNT_W)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
	.wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .destOut(destOut),
	.flagsOut(flagsOut), .busyOut(busyOut), .opDone(opDone));

// ===== sim/sbalu_top_tb.sv
/* shift_and_borrow_subtract_alu_tb: table-driven bench for sbalu_top.
 * assumes: sbalu_wb_host as bus master and sbalu_chk bound to the design. */
`timescale 1ns/1ps
module shift_and_borrow_subtract_alu_tb;
	typedef struct packed {
		logic [1:0]  op;
		logic        word;
		logic        csel;
		logic [7:0]  cnt;
		logic [15:0] dest;
		logic [15:0] src;
		logic [15:0] fIn;
		logic [15:0] expD;
		logic [15:0] expF;
	} sbalu_row_s;
	localparam sbalu_row_s ROWS [9] = '{
		'{2'h0, 1'b1, 1'b0, 8'h01, 16'h4001, 16'h0000, 16'h0700, 16'h8002, 16'h0f80},
		'{2'h1, 1'b0, 1'b1, 8'h03, 16'hab81, 16'h0000, 16'h0701, 16'hab08, 16'h0700},
		'{2'h2, 1'b1, 1'b0, 8'h01, 16'hfffb, 16'h0000, 16'h0700, 16'hfffd, 16'h0781},
		'{2'h2, 1'b0, 1'b0, 8'h02, 16'h1240, 16'h0000, 16'h0f01, 16'h1210, 16'h0700},
		'{2'h3, 1'b1, 1'b0, 8'h00, 16'h0005, 16'h0005, 16'h0701, 16'hffff, 16'h0795},
		'{2'h3, 1'b0, 1'b0, 8'h00, 16'h3480, 16'h0001, 16'h0700, 16'h347f, 16'h0f10},
		'{2'h3, 1'b1, 1'b0, 8'h00, 16'h1234, 16'h1233, 16'h0701, 16'h0000, 16'h0744},
		'{2'h0, 1'b1, 1'b0, 8'h00, 16'h5a5a, 16'h0000, 16'h0f95, 16'h5a5a, 16'h0f95},
		'{2'h0, 1'b1, 1'b1, 8'h10, 16'hffff, 16'h0000, 16'h0700, 16'h0000, 16'h0f45}};
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wbCyc, wbStb, wbWe, wbAck, busyOut, opDone;
	logic [7:0]  wbAdr;
	logic [3:0]  wbSel;
	logic [31:0] wbDatW, wbDatR, rdat;
	logic [15:0] destOut, flagsOut;
	int          err_total = 0;
	int          n_tests = 0;
	always #50 ref_clk = ~ref_clk;
	sbalu_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb),
		.wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
		.wbAck(wbAck), .destOut(destOut), .flagsOut(flagsOut), .busyOut(busyOut),
		.opDone(opDone));
	sbalu_wb_host u_host (.ref_clk(ref_clk), .wbAck(wbAck), .wbDatR(wbDatR), .wbCyc(wbCyc),
		.wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic wait_idle;
		do u_host.rd(sbalu_pkg::ADR_STATUS, rdat); while (rdat[0] !== 1'b0);
	endtask : wait_idle
	task automatic run(input sbalu_row_s r);
		u_host.wr(sbalu_pkg::ADR_FLAGS, {16'h0000, r.fIn}, 4'h3);
		u_host.wr(sbalu_pkg::ADR_DEST, {16'h0000, r.dest}, 4'h3);
		u_host.wr(sbalu_pkg::ADR_SRC, {16'h0000, r.src}, 4'h3);
		u_host.wr(r.csel ? sbalu_pkg::ADR_COUNTREG : sbalu_pkg::ADR_COUNTIMM,
			{24'h000000, r.cnt}, 4'h1);
		u_host.wr(sbalu_pkg::ADR_CTRL, {23'h000000, 1'b1, 4'h0, r.csel, r.word, r.op}, 4'h3);
		wait_idle();
	endtask : run
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		$display("wrong value at %0t: watchdog expired", $time);
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		chk({destOut, flagsOut}, 32'h0000_0000);
		u_host.rd(8'h40, rdat);
		chk(rdat, 32'h0000_0000);
		$display("reset and unmapped read done");
		for (int i = 0; i < 9; i++) begin
			run(ROWS[i]);
			chk({16'h0000, destOut}, {16'h0000, ROWS[i].expD});
			chk({16'h0000, flagsOut}, {16'h0000, ROWS[i].expF});
			u_host.rd(sbalu_pkg::ADR_DEST, rdat);
			chk({16'h0000, rdat[15:0]}, {16'h0000, ROWS[i].expD});
			$display("row %0d done", i);
		end
		run('{2'h1, 1'b1, 1'b0, 8'h00, 16'h0001, 16'h0000, 16'h0700, 16'h0000, 16'h0000});
		u_host.wr(sbalu_pkg::ADR_COUNTIMM, 32'h0000_0008, 4'h1);
		u_host.wr(sbalu_pkg::ADR_CTRL, 32'h0000_0105, 4'h3);
		u_host.wr(sbalu_pkg::ADR_DEST, 32'h0000_ffff, 4'h3);
		u_host.wr(sbalu_pkg::ADR_CTRL, 32'h0000_0103, 4'h3);
		wait_idle();
		chk({destOut, flagsOut}, 32'h0100_0704);
		chk({31'h0, rdat[1]}, 32'h0000_0001);
		$display("writes during shift done");
		u_host.wr(sbalu_pkg::ADR_COUNTIMM, 32'h0000_00c8, 4'h1);
		u_host.wr(sbalu_pkg::ADR_CTRL, 32'h0000_0100, 4'h3);
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk({15'h0000, busyOut, destOut}, 32'h0000_0000);
		chk({16'h0000, flagsOut}, 32'h0000_0000);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		u_host.rd(sbalu_pkg::ADR_STATUS, rdat);
		chk(rdat, 32'h0000_0000);
		$display("reset during shift done");
		wrap_up();
	end
endmodule : shift_and_borrow_subtract_alu_tb

// ===== sim/sbalu_wb_host.sv
/* sbalu_wb_host: classic wishbone master standing in for the core's decoder.
 * assumes: slave acks every request; the bench watchdog ends any hang. */
`timescale 1ns/1ps
module sbalu_wb_host (
	input  wire logic        ref_clk,
	input  wire logic        wbAck,
	input  wire logic [31:0] wbDatR,
	output logic             wbCyc,
	output logic             wbStb,
	output logic             wbWe,
	output logic      [7:0]  wbAdr,
	output logic      [3:0]  wbSel,
	output logic      [31:0] wbDatW
);
	initial begin
		{wbCyc, wbStb, wbWe, wbAdr, wbSel} = 15'h0000;
		wbDatW = 32'h0000_0000;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatW <= d;
		wbSel <= s;
		do @(posedge ref_clk); while (wbAck !== 1'b1);
		q = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbDatW <= ~d;
		@(posedge ref_clk);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		xfer(1'b1, a, d, s, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0000_0000, 4'hf, q);
	endtask : rd
endmodule : sbalu_wb_host
